// ---- src/perf_monitor_id_regs.sv ----
// Read side of the configuration and monitor identification system registers
`timescale 1ns/1ns
//////////////////////////////////////////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - An EL1 read of core_config_info traps to EL2 with class 0x18 when EL2 is enabled and trap_impl_defined_regs is set.
// - An EL1 read of monitor_machine_ident traps to EL2 with class 0x18 when EL2 is on and both fine-grained bits are set.
// - Otherwise an EL1 read of monitor_machine_ident traps to EL2 when EL2 is on and the EL2 trap_monitor_regs is set.
// - With the EL3 trap_monitor_regs set, EL1 (after EL2 checks) and EL2 reads trap to EL3; EL3 reads always succeed.
// - Bits [7:0] of monitor_machine_ident give the operation width, which is 8.
// - Without the stall-slot event the operation width field reads as zero.
// - Bits [63:8] of monitor_machine_ident read as zero.
// - Bits [63:32] of monitor_control read as zero.
// - The implementer field [31:24] of monitor_control carries no identity and reads as zero.
// - Bits [15:11] of monitor_control give the counter count, 6 or 20 depending on the build.
// - Bits [23:16] and [10:8] of monitor_control read as zero.
// - monitor_machine_ident decodes at op0 3, CRn 9, op1 0, CRm 14, op2 6 and is 64 bits wide.
// - monitor_control decodes at op0 3, CRn 9, op1 3, CRm 12, op2 0 and is 64 bits wide.
// - The two common event identification registers decode at CRm 12 with op2 6 and op2 7, 64 bits each.
//////////////////////////////////////////////////////////////////////////////////////////////////////////////////////
module perf_monitor_id_regs
  import perf_monitor_id_pkg::*;
#(
  parameter bit TWENTY_COUNTERS = 1'b0,
  parameter bit HAS_STALL_SLOT  = 1'b1
)
(
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  // Read request
  input  wire logic         rd_valid,
  input  wire sysreg_enc_t  rd_enc,
  input  wire excp_level_t  rd_level,
  input  wire trap_ctrl_t   trap_ctrl,
  // Core configuration straps, monitor control low bits from the counter logic and event identification values
  input  wire logic         cfg_vpu_four,
  input  wire logic         cfg_no_scu,
  input  wire logic         cfg_ecc,
  input  wire logic [7:0]   ctrl_low_bits,
  input  wire logic [63:0]  event_ident_lo,
  input  wire logic [63:0]  event_ident_hi,
  // Read answer
  output logic              rsp_valid_q,
  output read_result_t      rsp_result_q,
  output logic [5:0]        rsp_class_q,
  output logic              rsp_hit_q,
  output logic [63:0]       rsp_data_q
);

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  function automatic logic enc_match(input sysreg_enc_t a, input sysreg_enc_t b);
    enc_match = (a == b);
  endfunction

  function automatic logic is_trap(input read_result_t r);
    is_trap = (r == RES_TRAP_E2) || (r == RES_TRAP_E3);
  endfunction

  logic         hit_cfg;
  logic         hit_mmi;
  logic         hit_ctl;
  logic         hit_elo;
  logic         hit_ehi;
  logic         any_hit;
  read_result_t result_d;
  logic [63:0]  value_d;
  logic [63:0]  mmi_value;
  logic [63:0]  ctl_value;
  logic [63:0]  cfg_value;

  assign hit_cfg = enc_match(rd_enc, ENC_CORE_CONFIG_INFO);
  assign hit_mmi = enc_match(rd_enc, ENC_MACHINE_IDENT);
  assign hit_ctl = enc_match(rd_enc, ENC_MONITOR_CONTROL);
  assign hit_elo = enc_match(rd_enc, ENC_EVENT_IDENT_LO);
  assign hit_ehi = enc_match(rd_enc, ENC_EVENT_IDENT_HI);
  assign any_hit = hit_cfg | hit_mmi | hit_ctl | hit_elo | hit_ehi;

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Register contents; reserved bits start from zero
  always_comb
  begin
    mmi_value = ZERO64;
    if (HAS_STALL_SLOT)
    begin
      mmi_value[OPW_MSB:OPW_LSB] = OPW_VALUE;
    end
    else
    begin
      mmi_value[OPW_MSB:OPW_LSB] = OPW_ABSENT;
    end
  end

  always_comb
  begin
    ctl_value                    = ZERO64;
    ctl_value[IMPL_MSB:IMPL_LSB] = IMPL_NONE;
    ctl_value[NCNT_MSB:NCNT_LSB] = TWENTY_COUNTERS ? NCNT_TWENTY : NCNT_SIX;
    // Low control bits belong to the counter logic and pass through untouched
    ctl_value[CTL_LOW_MSB:CTL_LOW_LSB] = ctrl_low_bits;
  end

  always_comb
  begin
    cfg_value                = ZERO64;
    cfg_value[CFG_VPU_BIT]   = cfg_vpu_four;
    cfg_value[CFG_NOSCU_BIT] = cfg_no_scu;
    cfg_value[CFG_ECC_BIT]   = cfg_ecc;
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Access checks; the monitor control and event registers are not gated here, their checks live elsewhere
  // Fine-grained trap outranks the coarse EL2 trap and both outrank EL3, so EL1 readers see EL2 first
  always_comb
  begin
    result_d = RES_VALUE;
    value_d  = ZERO64;
    if (hit_cfg)
    begin
      if (rd_level == EL_0)
        result_d = RES_UNDEF;
      else if (rd_level == EL_1 && trap_ctrl.el2_enabled && trap_ctrl.trap_impl_defined_regs)
        result_d = RES_TRAP_E2;
      else
        value_d = cfg_value;
    end
    else if (hit_mmi)
    begin
      if (rd_level == EL_0)
        result_d = RES_UNDEF;
      else if (rd_level == EL_1 && trap_ctrl.el2_enabled && trap_ctrl.fine_grained_trap_allow
               && trap_ctrl.fgt_read_monitor_machine_ident)
        result_d = RES_TRAP_E2;
      else if (rd_level == EL_1 && trap_ctrl.el2_enabled && trap_ctrl.el2_trap_monitor_regs)
        result_d = RES_TRAP_E2;
      else if (rd_level != EL_3 && trap_ctrl.el3_trap_monitor_regs)
        result_d = RES_TRAP_E3;
      else
        value_d = mmi_value;
    end
    else if (hit_ctl)
      value_d = ctl_value;
    else if (hit_elo)
      value_d = event_ident_lo;
    else if (hit_ehi)
      value_d = event_ident_hi;
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Registered answer, one cycle after the request; each field has its own flops
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_valid_q <= 1'b0;
    end
    else
    begin
      rsp_valid_q <= rd_valid;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_hit_q <= 1'b0;
    end
    else
    begin
      rsp_hit_q <= rd_valid & any_hit;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_result_q <= RES_VALUE;
    end
    else
    begin
      rsp_result_q <= rd_valid ? result_d : RES_VALUE;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_class_q <= EC_NONE;
    end
    else
    begin
      rsp_class_q <= (rd_valid && is_trap(result_d)) ? EC_SYS_ACCESS : EC_NONE;
    end
  end

  // Refused reads return zero so a trapped or undefined access never leaks contents
  always_ff @(posedge sys_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rsp_data_q <= ZERO64;
    end
    else
    begin
      rsp_data_q <= (rd_valid && result_d == RES_VALUE) ? value_d : ZERO64;
    end
  end

  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Checks look at the registered answer one cycle after each request
  chk_cfg_trap_el2: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && hit_cfg && rd_level == EL_1 && trap_ctrl.el2_enabled && trap_ctrl.trap_impl_defined_regs
    |=> rsp_result_q == RES_TRAP_E2 && rsp_class_q == EC_SYS_ACCESS)
    else $error("config read not trapped to EL2");

  chk_mmi_fgt_trap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && hit_mmi && rd_level == EL_1 && trap_ctrl.el2_enabled && trap_ctrl.fine_grained_trap_allow
    && trap_ctrl.fgt_read_monitor_machine_ident |=> rsp_result_q == RES_TRAP_E2)
    else $error("fine grained trap missed");

  chk_mmi_el2_trap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && hit_mmi && rd_level == EL_1 && trap_ctrl.el2_enabled && trap_ctrl.el2_trap_monitor_regs
    |=> rsp_result_q == RES_TRAP_E2 && rsp_data_q == ZERO64)
    else $error("EL2 monitor trap missed");

  chk_mmi_el3_trap: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && hit_mmi && rd_level == EL_2 && trap_ctrl.el3_trap_monitor_regs
    |=> rsp_result_q == RES_TRAP_E3 && rsp_class_q == EC_SYS_ACCESS)
    else $error("EL3 monitor trap missed");

  chk_mmi_el3_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && hit_mmi && rd_level == EL_3 |=> rsp_result_q == RES_VALUE)
    else $error("EL3 read refused");

  chk_mmi_value: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && rd_enc == ENC_MACHINE_IDENT && rd_level == EL_3 && HAS_STALL_SLOT
    |=> rsp_data_q[OPW_MSB:OPW_LSB] == OPW_VALUE)
    else $error("machine ident value wrong");

  chk_ctl_fields: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && hit_ctl |=> rsp_data_q[CTL_RSV_MSB:CTL_RSV_LSB] == '0 && rsp_data_q[IMPL_MSB:IMPL_LSB] == IMPL_NONE
    && rsp_data_q[CTL_GAP_HI_MSB:CTL_GAP_HI_LSB] == '0 && rsp_data_q[CTL_GAP_LO_MSB:CTL_GAP_LO_LSB] == '0
    && rsp_data_q[NCNT_MSB:NCNT_LSB] == (TWENTY_COUNTERS ? NCNT_TWENTY : NCNT_SIX))
    else $error("control fields wrong");

  chk_el0_undef: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && (hit_cfg || hit_mmi) && rd_level == EL_0
    |=> rsp_result_q == RES_UNDEF && rsp_data_q == ZERO64 && rsp_class_q == EC_NONE)
    else $error("EL0 read not undefined");

  chk_event_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && rd_enc == ENC_EVENT_IDENT_HI |=> rsp_hit_q && rsp_data_q == $past(event_ident_hi))
    else $error("event ident hi decode wrong");

  chk_cfg_el1_read: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && rd_enc == ENC_CORE_CONFIG_INFO && rd_level == EL_1
    && !(trap_ctrl.el2_enabled && trap_ctrl.trap_impl_defined_regs) |=> rsp_result_q == RES_VALUE && rsp_hit_q)
    else $error("config read trapped without cause");

  chk_mmi_el1_el3: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && rd_enc == ENC_MACHINE_IDENT && rd_level == EL_1 && !trap_ctrl.el2_enabled
    && trap_ctrl.el3_trap_monitor_regs |=> rsp_result_q == RES_TRAP_E3 && rsp_class_q == EC_SYS_ACCESS)
    else $error("EL1 read not trapped to EL3");

  chk_mmi_no_stall: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && rd_enc == ENC_MACHINE_IDENT && rd_level == EL_3 && !HAS_STALL_SLOT
    |=> rsp_data_q[OPW_MSB:OPW_LSB] == OPW_ABSENT)
    else $error("operation width not zero without stall slots");

  chk_mmi_reserved: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && rd_enc == ENC_MACHINE_IDENT && rd_level == EL_3
    |=> rsp_data_q[MMI_RSV_MSB:MMI_RSV_LSB] == '0)
    else $error("machine ident reserved bits set");

  chk_ctl_upper_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && rd_enc == ENC_MONITOR_CONTROL |=> rsp_data_q[CTL_RSV_MSB:CTL_RSV_LSB] == '0)
    else $error("control upper half not zero");

  chk_ctl_impl_none: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && rd_enc == ENC_MONITOR_CONTROL |=> rsp_data_q[IMPL_MSB:IMPL_LSB] == IMPL_NONE)
    else $error("control implementer field not empty");

  chk_ctl_gaps_zero: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && rd_enc == ENC_MONITOR_CONTROL |=> rsp_data_q[CTL_GAP_HI_MSB:CTL_GAP_HI_LSB] == '0
    && rsp_data_q[CTL_GAP_LO_MSB:CTL_GAP_LO_LSB] == '0)
    else $error("control reserved gaps not zero");

  chk_mmi_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && rd_enc == ENC_MACHINE_IDENT && rd_level == EL_3
    |=> rsp_hit_q && rsp_result_q == RES_VALUE && rsp_class_q == EC_NONE)
    else $error("machine ident decode wrong");

  chk_ctl_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && rd_enc == ENC_MONITOR_CONTROL |=> rsp_hit_q && rsp_result_q == RES_VALUE
    && rsp_data_q[CTL_LOW_MSB:CTL_LOW_LSB] == $past(ctrl_low_bits))
    else $error("control decode wrong");

  chk_event_lo_decode: assert property (@(posedge sys_clk) disable iff (!rst_n)
    rd_valid && rd_enc == ENC_EVENT_IDENT_LO |=> rsp_hit_q && rsp_data_q == $past(event_ident_lo))
    else $error("event ident lo decode wrong");

  chk_answer_idle: assert property (@(posedge sys_clk) disable iff (!rst_n)
    !rd_valid |=> !rsp_valid_q && !rsp_hit_q && rsp_class_q == EC_NONE && rsp_data_q == ZERO64)
    else $error("answer present without request");

endmodule

// ---- src/perf_monitor_id_pkg.sv ----
// Package: encodings, field layouts and types for the monitor identification register block
package perf_monitor_id_pkg;

  // Exception levels
  typedef enum logic [1:0]
  {
    EL_0 = 2'h0,
    EL_1 = 2'h1,
    EL_2 = 2'h2,
    EL_3 = 2'h3
  } excp_level_t;

  // Read outcome
  typedef enum logic [1:0]
  {
    RES_VALUE   = 2'h0,
    RES_UNDEF   = 2'h1,
    RES_TRAP_E2 = 2'h2,
    RES_TRAP_E3 = 2'h3
  } read_result_t;

  // System register encoding
  typedef struct packed
  {
    logic [1:0] op0;
    logic [2:0] op1;
    logic [3:0] crn;
    logic [3:0] crm;
    logic [2:0] op2;
  } sysreg_enc_t;

  // Trap control bits seen by the block
  typedef struct packed
  {
    logic el2_enabled;
    logic trap_impl_defined_regs;
    logic fine_grained_trap_allow;
    logic fgt_read_monitor_machine_ident;
    logic el2_trap_monitor_regs;
    logic el3_trap_monitor_regs;
  } trap_ctrl_t;

  localparam sysreg_enc_t ENC_CORE_CONFIG_INFO = '{op0: 2'h3, op1: 3'h0, crn: 4'hF, crm: 4'h0, op2: 3'h0};
  localparam sysreg_enc_t ENC_MACHINE_IDENT    = '{op0: 2'h3, op1: 3'h0, crn: 4'h9, crm: 4'hE, op2: 3'h6};
  localparam sysreg_enc_t ENC_MONITOR_CONTROL  = '{op0: 2'h3, op1: 3'h3, crn: 4'h9, crm: 4'hC, op2: 3'h0};
  localparam sysreg_enc_t ENC_EVENT_IDENT_LO   = '{op0: 2'h3, op1: 3'h3, crn: 4'h9, crm: 4'hC, op2: 3'h6};
  localparam sysreg_enc_t ENC_EVENT_IDENT_HI   = '{op0: 2'h3, op1: 3'h3, crn: 4'h9, crm: 4'hC, op2: 3'h7};

  localparam logic [5:0]  EC_SYS_ACCESS     = 6'h18;
  localparam int          REG_W             = 64;
  localparam int          OPW_LSB           = 0;
  localparam int          OPW_MSB           = 7;
  localparam logic [7:0]  OPW_VALUE         = 8'h08;
  localparam int          IMPL_LSB          = 24;
  localparam int          IMPL_MSB          = 31;
  localparam logic [7:0]  IMPL_NONE         = 8'h00;
  localparam int          NCNT_LSB          = 11;
  localparam int          NCNT_MSB          = 15;
  localparam logic [4:0]  NCNT_SIX          = 5'h06;
  localparam logic [4:0]  NCNT_TWENTY       = 5'h14;
  localparam int          CFG_VPU_BIT       = 5;
  localparam int          CFG_NOSCU_BIT     = 2;
  localparam int          CFG_ECC_BIT       = 0;
  localparam logic [63:0] ZERO64            = 64'h0000_0000_0000_0000;
  localparam logic [5:0]  EC_NONE           = 6'h00;
  localparam logic [7:0]  OPW_ABSENT        = 8'h00;
  localparam int          MMI_RSV_LSB       = 8;
  localparam int          MMI_RSV_MSB       = 63;
  localparam int          CTL_LOW_LSB       = 0;
  localparam int          CTL_LOW_MSB       = 7;
  localparam int          CTL_GAP_LO_LSB    = 8;
  localparam int          CTL_GAP_LO_MSB    = 10;
  localparam int          CTL_GAP_HI_LSB    = 16;
  localparam int          CTL_GAP_HI_MSB    = 23;
  localparam int          CTL_RSV_LSB       = 32;
  localparam int          CTL_RSV_MSB       = 63;

endpackage

// ---- testbench/tb_top.sv ----
// Self-checking bench for the monitor identification register read block
`timescale 1ns/1ns
module tb_top;
  import perf_monitor_id_pkg::*;
  logic         sys_clk;
  logic         rst_n;
  logic         rd_valid;
  sysreg_enc_t  rd_enc;
  excp_level_t  rd_level;
  trap_ctrl_t   trap_ctrl;
  logic         rsp_valid_q;
  read_result_t rsp_result_q;
  logic [5:0]   rsp_class_q;
  logic         rsp_hit_q;
  logic [63:0]  rsp_data_q;
  logic [63:0]  alt_data;
  logic         cfg_vpu_four;
  logic         cfg_no_scu;
  logic         cfg_ecc;
  logic [7:0]   ctrl_low_bits;
  logic [63:0]  ev_lo;
  logic [63:0]  ev_hi;
  int           fail_count;
  int           checks_done;
  // Straps and pass-through contents; bit 6 of the low control bits is set on purpose
  localparam logic [63:0] CFG   = 64'h0000_0000_0000_0024;
  localparam logic [63:0] CTL6  = 64'h0000_0000_0000_3045;
  localparam logic [63:0] CTL20 = 64'h0000_0000_0000_A045;
  localparam logic [63:0] EVLO  = 64'h0123_4567_89AB_CDEF;
  localparam logic [63:0] EVHI  = 64'hFEDC_BA98_7654_3210;
  localparam sysreg_enc_t ENC_UNMAPPED = '{op0: 2'h3, op1: 3'h3, crn: 4'h9, crm: 4'hC, op2: 3'h5};
  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Two builds side by side: six counters with stall slots, twenty counters without
  perf_monitor_id_regs #(.TWENTY_COUNTERS(1'b0), .HAS_STALL_SLOT(1'b1)) uut
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .rd_valid(rd_valid), .rd_enc(rd_enc), .rd_level(rd_level),
    .trap_ctrl(trap_ctrl), .cfg_vpu_four(cfg_vpu_four), .cfg_no_scu(cfg_no_scu), .cfg_ecc(cfg_ecc),
    .ctrl_low_bits(ctrl_low_bits), .event_ident_lo(ev_lo), .event_ident_hi(ev_hi), .rsp_valid_q(rsp_valid_q),
    .rsp_result_q(rsp_result_q), .rsp_class_q(rsp_class_q), .rsp_hit_q(rsp_hit_q), .rsp_data_q(rsp_data_q)
  );
  perf_monitor_id_regs #(.TWENTY_COUNTERS(1'b1), .HAS_STALL_SLOT(1'b0)) uut_twenty
  (
    .sys_clk(sys_clk), .rst_n(rst_n), .rd_valid(rd_valid), .rd_enc(rd_enc), .rd_level(rd_level),
    .trap_ctrl(trap_ctrl), .cfg_vpu_four(cfg_vpu_four), .cfg_no_scu(cfg_no_scu), .cfg_ecc(cfg_ecc),
    .ctrl_low_bits(ctrl_low_bits), .event_ident_lo(ev_lo), .event_ident_hi(ev_hi), .rsp_valid_q(),
    .rsp_result_q(), .rsp_class_q(),
    .rsp_hit_q(), .rsp_data_q(alt_data)
  );
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // rd_valid stays high between calls so reads stream back to back
  task automatic rd(input sysreg_enc_t e, input excp_level_t l, input logic [5:0] t, input read_result_t r,
                    input logic h, input logic [63:0] d);
    logic trap;
    trap      = (r == RES_TRAP_E2) || (r == RES_TRAP_E3);
    rd_valid  = 1'b1;
    rd_enc    = e;
    rd_level  = l;
    trap_ctrl = trap_ctrl_t'(t);
    @(negedge sys_clk);
    chk(64'(rsp_valid_q), 64'h1);
    chk(64'(rsp_result_q), 64'(r));
    chk(64'(rsp_class_q), trap ? 64'(EC_SYS_ACCESS) : 64'h0);
    chk(64'(rsp_hit_q), 64'(h));
    chk(rsp_data_q, (r == RES_VALUE) ? d : 64'h0);
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////////////////////////////////////////
  // Trap bits, high to low: el2 on, impl regs, fgt allow, fgt read, el2 monitor, el3 monitor
  initial
  begin
    fail_count  = 0;
    checks_done = 0;
    rst_n       = 1'b0;
    rd_valid    = 1'b0;
    rd_enc      = ENC_MACHINE_IDENT;
    rd_level    = EL_0;
    trap_ctrl   = trap_ctrl_t'(6'h00);
    cfg_vpu_four  = 1'b1;
    cfg_no_scu    = 1'b1;
    cfg_ecc       = 1'b0;
    ctrl_low_bits = 8'h45;
    ev_lo         = EVLO;
    ev_hi         = EVHI;
    repeat (12) @(negedge sys_clk);
    rst_n = 1'b1;
    @(negedge sys_clk);
    chk({rsp_data_q[63:1], rsp_valid_q}, 64'h0);
    rd(ENC_CORE_CONFIG_INFO, EL_1, 6'h30, RES_TRAP_E2, 1'b1, CFG);
    rd(ENC_CORE_CONFIG_INFO, EL_1, 6'h1F, RES_VALUE, 1'b1, CFG);
    rd(ENC_CORE_CONFIG_INFO, EL_2, 6'h3F, RES_VALUE, 1'b1, CFG);
    rd(ENC_CORE_CONFIG_INFO, EL_3, 6'h3F, RES_VALUE, 1'b1, CFG);
    rd(ENC_CORE_CONFIG_INFO, EL_0, 6'h00, RES_UNDEF, 1'b1, 64'h0);
    $display("test core config done");
    rd(ENC_MACHINE_IDENT, EL_1, 6'h2D, RES_TRAP_E2, 1'b1, 64'h0);
    rd(ENC_MACHINE_IDENT, EL_1, 6'h25, RES_TRAP_E3, 1'b1, 64'h0);
    rd(ENC_MACHINE_IDENT, EL_1, 6'h23, RES_TRAP_E2, 1'b1, 64'h0);
    rd(ENC_MACHINE_IDENT, EL_1, 6'h03, RES_TRAP_E3, 1'b1, 64'h0);
    rd(ENC_MACHINE_IDENT, EL_1, 6'h21, RES_TRAP_E3, 1'b1, 64'h0);
    rd(ENC_MACHINE_IDENT, EL_2, 6'h3E, RES_VALUE, 1'b1, 64'h8);
    rd(ENC_MACHINE_IDENT, EL_2, 6'h01, RES_TRAP_E3, 1'b1, 64'h0);
    rd(ENC_MACHINE_IDENT, EL_3, 6'h3F, RES_VALUE, 1'b1, 64'h8);
    rd(ENC_MACHINE_IDENT, EL_1, 6'h00, RES_VALUE, 1'b1, 64'h8);
    chk(alt_data, 64'h0);
    rd(ENC_MACHINE_IDENT, EL_0, 6'h00, RES_UNDEF, 1'b1, 64'h0);
    $display("test machine ident done");
    rd(ENC_MONITOR_CONTROL, EL_0, 6'h3F, RES_VALUE, 1'b1, CTL6);
    chk(alt_data, CTL20);
    rd(ENC_EVENT_IDENT_LO, EL_0, 6'h3F, RES_VALUE, 1'b1, EVLO);
    rd(ENC_EVENT_IDENT_HI, EL_1, 6'h3F, RES_VALUE, 1'b1, EVHI);
    // Straps and pass-through contents except ev_hi change so each changed input is seen to reach the answer
    cfg_vpu_four  = 1'b0;
    cfg_no_scu    = 1'b0;
    cfg_ecc       = 1'b1;
    ctrl_low_bits = 8'h5A;
    ev_lo         = EVHI;
    rd(ENC_CORE_CONFIG_INFO, EL_2, 6'h00, RES_VALUE, 1'b1, 64'h0000_0000_0000_0001);
    rd(ENC_MONITOR_CONTROL, EL_1, 6'h00, RES_VALUE, 1'b1, 64'h0000_0000_0000_305A);
    chk(alt_data, 64'h0000_0000_0000_A05A);
    rd(ENC_EVENT_IDENT_LO, EL_3, 6'h00, RES_VALUE, 1'b1, EVHI);
    rd(ENC_UNMAPPED, EL_1, 6'h00, RES_VALUE, 1'b0, 64'h0);
    $display("test control and event ident done");
    // Reset lands while a read is still being presented
    rst_n = 1'b0;
    #1;
    chk({rsp_data_q[63:1], rsp_valid_q}, 64'h0);
    @(negedge sys_clk);
    rst_n    = 1'b1;
    rd_valid = 1'b0;
    @(negedge sys_clk);
    chk(64'(rsp_valid_q), 64'h0);
    rd(ENC_MACHINE_IDENT, EL_3, 6'h00, RES_VALUE, 1'b1, 64'h8);
    $display("test reset mid run done");
    stop_test();
  end
endmodule
